//--- verilog/cie_regs.vh
`ifndef CIE_REGS_VH
`define CIE_REGS_VH
// Register map of the interrupt entry/exit block (AXI4-Lite byte offsets).
`define CIE_OFF_FLAG      8'h00
`define CIE_OFF_ENABLE    8'h04
`define CIE_OFF_LEVELTYPE 8'h08
`define CIE_OFF_CORECTRL  8'h0C
`define CIE_OFF_STATUS    8'h10
`define CIE_OFF_SP        8'h14
`define CIE_OFF_PC        8'h18
`define CIE_OFF_CMD       8'h1C
`define CIE_OFF_VECTOR    8'h20
`define CIE_OFF_STATE     8'h24
// Field positions.
`define CIE_GIE_BIT       7
`define CIE_RELOC_BIT     0
`define CIE_CMD_CLI       0
`define CIE_CMD_SEI       1
`define CIE_CMD_RETURN_FROM_HANDLER_INSTR      2
`define CIE_CMD_STEP      3
`define CIE_CMD_SLEEP     4
// Reset values.
`define CIE_SP_RESET      16'h04FF
`define CIE_STATUS_RESET  8'h00
// Timing counts in CPU clocks.
`define CIE_ENTRY_CYC     3'h4
`define CIE_WAKE_CYC      3'h4
`define CIE_RETURN_FROM_HANDLER_INSTR_CYC      3'h4
`define CIE_JMP_CYC       3'h3
// AXI responses.
`define CIE_RESP_OKAY     2'h0
`define CIE_RESP_SLVERR   2'h2
`endif

//--- verilog/cie_prio.v
`timescale 1ns/1ps
// Fixed-priority picker: the lowest index wins, like the lowest vector.
module cie_prio #(
  parameter N = 8,
  parameter W = 3
) (
  input wire [N-1:0] req, // Qualified requests.
  output reg any, // Some request present.
  output reg [W-1:0] idx // Winning index.
);
  integer i;

  // Scan from the top down so the lowest index is assigned last.
  always @* begin
    any = 1'b0;
    idx = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[W-1:0];
      end
    end
  end
endmodule

//--- verilog/cie_core.v
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cie_regs.vh"
// How it works
// [RULE_01] Distinct vectors; lower address wins priority.
// [RULE_02] Accept only with own and global enable.
// [RULE_03] Relocate bit moves table to boot start.
// [RULE_04] Boot reset fuse moves reset vector.
// [RULE_05] Boot lock bits suppress interrupts by region.
// [RULE_06] Taking an interrupt clears global enable.
// [RULE_07] Vectoring clears the flag-type source flag.
// [RULE_08] Writing one clears a flag bit.
// [RULE_09] Disabled flag-type events still latch flags.
// [RULE_10] Held flags served by priority later.
// [RULE_11] Level sources request only while present.
// [RULE_12] One main instruction after return.
// [RULE_13] Status flags not saved or restored.
// [RULE_14] Global disable acts at once.
// [RULE_15] One instruction after global enable first.
// [RULE_16] Entry takes four cycles, pushes counter.
// [RULE_17] Vector jump completes in three cycles.
// [RULE_18] Multi-cycle instructions finish before entry.
// [RULE_19] Wake from sleep adds four cycles.
// [RULE_20] Return takes four cycles, pops, sets enable.
// [RULE_21] Program counter is thirteen bits wide.
// [RULE_22] Undivided clock, single-cycle ALU steps.
// [RULE_23] Global enable lives in status bit seven.
// [RULE_24] Entry push decrements stack pointer by two.
module cie_core #(
  parameter NSRC = 8, // Interrupt sources; source 0 is external request 0.
  parameter IW = 3, // Index width.
  parameter PCW = 13, // Program counter width.
  parameter [12:0] BOOT_START = 13'h1C00 // Start of boot section.
) (
  input wire CORE_CLK, // CPU clock.
  input wire RST, // Asynchronous reset, active high.
  input wire [NSRC-1:0] SRC_EVENT, // Flag-type event pulses.
  input wire [NSRC-1:0] SRC_LEVEL, // Level-type conditions.
  input wire INSTR_DONE, // Sequencer: instruction boundary reached.
  input wire BOOT_RESET_FUSE, // Programmed boot reset fuse.
  input wire APP_SECTION_LOCK_BIT, // Programmed application lock.
  input wire BOOT_SECTION_LOCK_BIT, // Programmed boot lock.
  input wire [31:0] S_AXI_AWADDR, // Write address.
  input wire S_AXI_AWVALID, // Write address valid.
  output reg S_AXI_AWREADY, // Write address ready.
  input wire [31:0] S_AXI_WDATA, // Write data.
  input wire [3:0] S_AXI_WSTRB, // Write strobes.
  input wire S_AXI_WVALID, // Write data valid.
  output reg S_AXI_WREADY, // Write data ready.
  output reg [1:0] S_AXI_BRESP, // Write response.
  output reg S_AXI_BVALID, // Write response valid.
  input wire S_AXI_BREADY, // Write response ready.
  input wire [31:0] S_AXI_ARADDR, // Read address.
  input wire S_AXI_ARVALID, // Read address valid.
  output reg S_AXI_ARREADY, // Read address ready.
  output reg [31:0] S_AXI_RDATA, // Read data.
  output reg [1:0] S_AXI_RRESP, // Read response.
  output reg S_AXI_RVALID, // Read data valid.
  input wire S_AXI_RREADY, // Read data ready.
  output reg [PCW-1:0] PROGRAM_COUNTER, // Current program counter.
  output reg STACK_WE, // Stack write strobe.
  output reg [15:0] STACK_ADDR, // Stack byte address.
  output reg [7:0] STACK_WDATA, // Stack write byte.
  output reg CORE_STALL // Sequencer held by sleep, entry or return.
);
  localparam ST_RUN = 3'h0;
  localparam ST_WAKE = 3'h1;
  localparam ST_ENTRY = 3'h2;
  localparam ST_JUMP = 3'h3;
  localparam ST_RETURN_FROM_HANDLER_INSTR = 3'h4;
  localparam ST_SLEEP = 3'h5;

  reg [NSRC-1:0] flag;
  reg [NSRC-1:0] enable;
  reg [NSRC-1:0] level_type;
  reg reloc;
  reg [7:0] status_flags_register;
  reg [15:0] sp;
  reg [2:0] state;
  reg [2:0] cnt;
  reg [IW-1:0] cur;
  reg hold_one;
  reg [PCW-1:0] ret_pc;
  reg [7:0] cmd_reg;
  reg aw_got;
  reg w_got;
  reg [7:0] aw_off;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg booted;

  wire gie = status_flags_register[`CIE_GIE_BIT];
  wire [NSRC-1:0] pend;
  wire any;
  wire [IW-1:0] win;
  wire in_boot = (PROGRAM_COUNTER >= BOOT_START);
  wire wr_go = aw_got && w_got && !S_AXI_BVALID;
  wire wr_cmd = wr_go && (aw_off == `CIE_OFF_CMD) && w_strb[0];
  wire cli_now = wr_cmd && w_data[`CIE_CMD_CLI];
  wire [PCW-1:0] vec_base = reloc ? BOOT_START : {PCW{1'b0}};
  wire [PCW-1:0] vec_addr;
  wire lock_block;
  wire can_take;

  // Level sources request only while the condition is there; flag
  // sources request from the latched flag.
  assign pend = ((level_type & SRC_LEVEL) | (~level_type & flag)) // [RULE_11]
    & enable; // [RULE_02]
  // Lock bits stop vectoring into the other section, by where we run.
  assign lock_block = (in_boot && APP_SECTION_LOCK_BIT && !reloc) ||
    (!in_boot && BOOT_SECTION_LOCK_BIT && reloc); // [RULE_05]
  // Vector word address: reset at base, sources at base + 2*(i+1).
  assign vec_addr = vec_base +
    {{(PCW-IW-2){1'b0}}, win, 1'b0} + 13'h0002; // [RULE_01] [RULE_03]
  // CLI in the same cycle blocks the take; a pending SEI or return
  // leaves one instruction to run first.
  assign can_take = any && gie && !cli_now && !hold_one && // [RULE_14]
    !lock_block && INSTR_DONE; // [RULE_18] [RULE_12] [RULE_15]

  cie_prio #(.N(NSRC), .W(IW)) u_prio (
    .req(pend),
    .any(any),
    .idx(win)
  );

  // Flags: hardware set wins over a software or vectoring clear.
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_flag
      wire sw_clr = wr_go && (aw_off == `CIE_OFF_FLAG) &&
        w_strb[g / 8] && w_data[g]; // [RULE_08]
      // A wake from sleep vectors too, so it must clear the flag as well.
      wire hw_clr = ((state == ST_RUN && can_take) ||
        (state == ST_SLEEP && any && gie && !lock_block)) &&
        (win == g) && !level_type[g]; // [RULE_07]
      always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          flag[g] <= 1'b0;
        end else if (SRC_EVENT[g]) begin
          flag[g] <= 1'b1; // [RULE_09] [RULE_10]
        end else if (sw_clr || hw_clr) begin
          flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Entry and return sequencer with the stack traffic.
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_RUN;
      cnt <= 3'h0;
      cur <= {IW{1'b0}};
      hold_one <= 1'b0;
      ret_pc <= {PCW{1'b0}};
      PROGRAM_COUNTER <= {PCW{1'b0}};
      sp <= `CIE_SP_RESET;
      status_flags_register <= `CIE_STATUS_RESET;
      STACK_WE <= 1'b0;
      STACK_ADDR <= 16'h0000;
      STACK_WDATA <= 8'h00;
      CORE_STALL <= 1'b0;
      booted <= 1'b0;
    end else begin
      STACK_WE <= 1'b0;
      // Reset vector is caught after release, not under reset.
      if (!booted) begin
        booted <= 1'b1;
        PROGRAM_COUNTER <= BOOT_RESET_FUSE ? BOOT_START :
          {PCW{1'b0}}; // [RULE_04]
      end
      if (INSTR_DONE && state == ST_RUN) begin
        hold_one <= 1'b0;
      end
      // Software status write takes the whole byte, enable bit included;
      // the flags belong to the handler and are never stacked.
      if (wr_go && aw_off == `CIE_OFF_STATUS && w_strb[0]) begin
        status_flags_register <= w_data[7:0]; // [RULE_13] [RULE_23]
      end
      if (wr_cmd && w_data[`CIE_CMD_SEI] && !gie) begin
        status_flags_register[`CIE_GIE_BIT] <= 1'b1;
        hold_one <= 1'b1; // [RULE_15]
      end
      if (cli_now) begin
        status_flags_register[`CIE_GIE_BIT] <= 1'b0; // [RULE_14]
      end
      if (wr_go && aw_off == `CIE_OFF_PC) begin
        PROGRAM_COUNTER <= w_data[PCW-1:0]; // [RULE_21]
      end
      if (wr_go && aw_off == `CIE_OFF_SP && w_strb[0]) begin
        sp <= w_data[15:0];
      end
      case (state)
        ST_RUN: begin
          CORE_STALL <= 1'b0;
          if (can_take) begin
            // One clock per step, no division of the core clock.
            state <= ST_ENTRY; // [RULE_22]
            cur <= win;
            cnt <= `CIE_ENTRY_CYC - 3'h1;
            ret_pc <= PROGRAM_COUNTER;
            status_flags_register[`CIE_GIE_BIT] <= 1'b0; // [RULE_06]
            CORE_STALL <= 1'b1;
          end else if (wr_cmd && w_data[`CIE_CMD_RETURN_FROM_HANDLER_INSTR]) begin
            state <= ST_RETURN_FROM_HANDLER_INSTR;
            cnt <= `CIE_RETURN_FROM_HANDLER_INSTR_CYC - 3'h1;
            CORE_STALL <= 1'b1;
          end else if (wr_cmd && w_data[`CIE_CMD_SLEEP]) begin
            state <= ST_SLEEP;
            CORE_STALL <= 1'b1;
          end else if (wr_cmd && w_data[`CIE_CMD_STEP]) begin
            PROGRAM_COUNTER <= PROGRAM_COUNTER + 13'h0001;
          end
        end
        ST_SLEEP: begin
          if (any && gie && !lock_block) begin
            state <= ST_WAKE;
            cur <= win;
            cnt <= `CIE_WAKE_CYC - 3'h1;
            ret_pc <= PROGRAM_COUNTER;
            status_flags_register[`CIE_GIE_BIT] <= 1'b0; // [RULE_06]
          end
        end
        ST_WAKE: begin
          // Wake-up adds its own four clocks before entry starts.
          if (cnt == 3'h0) begin
            state <= ST_ENTRY;
            cnt <= `CIE_ENTRY_CYC - 3'h1; // [RULE_19]
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        ST_ENTRY: begin
          // Push low byte then high byte; pointer ends two lower.
          if (cnt == 3'h3 || cnt == 3'h2) begin
            STACK_WE <= 1'b1;
            STACK_ADDR <= sp;
            STACK_WDATA <= (cnt == 3'h3) ? ret_pc[7:0] :
              {3'h0, ret_pc[PCW-1:8]};
            sp <= sp - 16'h0001; // [RULE_24] [RULE_16]
          end
          if (cnt == 3'h0) begin
            state <= ST_JUMP;
            cnt <= `CIE_JMP_CYC - 3'h1;
            PROGRAM_COUNTER <= vec_addr; // [RULE_16]
            if (cur != win) begin
              PROGRAM_COUNTER <= vec_base + {{(PCW-IW-2){1'b0}},
                cur, 1'b0} + 13'h0002;
            end
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        ST_JUMP: begin
          // The vector jump is accounted as three stalled clocks.
          if (cnt == 3'h0) begin
            state <= ST_RUN; // [RULE_17]
            CORE_STALL <= 1'b0;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        ST_RETURN_FROM_HANDLER_INSTR: begin
          // Pop bookkeeping: pointer up by two, enable back on.
          if (cnt == 3'h0) begin
            state <= ST_RUN;
            PROGRAM_COUNTER <= ret_pc;
            sp <= sp + 16'h0002; // [RULE_20]
            status_flags_register[`CIE_GIE_BIT] <= 1'b1; // [RULE_20]
            hold_one <= 1'b1; // [RULE_12]
            CORE_STALL <= 1'b0;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Plain registers: enables, source type, relocation control.
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      enable <= {NSRC{1'b0}};
      level_type <= {NSRC{1'b0}};
      reloc <= 1'b0;
      cmd_reg <= 8'h00;
    end else if (wr_go) begin
      if (aw_off == `CIE_OFF_ENABLE) begin
        enable <= w_data[NSRC-1:0];
      end
      if (aw_off == `CIE_OFF_LEVELTYPE) begin
        level_type <= w_data[NSRC-1:0];
      end
      if (aw_off == `CIE_OFF_CORECTRL && w_strb[0]) begin
        reloc <= w_data[`CIE_RELOC_BIT]; // [RULE_03]
      end
      if (aw_off == `CIE_OFF_CMD) begin
        cmd_reg <= w_data[7:0];
      end
    end
  end

  // AXI write side: address and data taken in either order.
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_off <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `CIE_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_got && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_got && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_off <= S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_off > `CIE_OFF_CMD || aw_off[1:0] != 2'h0 ||
          aw_off == `CIE_OFF_VECTOR) ? `CIE_RESP_SLVERR : `CIE_RESP_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI read side; unmapped offsets answer with an error and zero.
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `CIE_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `CIE_RESP_OKAY;
        case (S_AXI_ARADDR[7:0])
          `CIE_OFF_FLAG: S_AXI_RDATA <= {{(32-NSRC){1'b0}}, flag};
          `CIE_OFF_ENABLE: S_AXI_RDATA <= {{(32-NSRC){1'b0}}, enable};
          `CIE_OFF_LEVELTYPE: S_AXI_RDATA <=
            {{(32-NSRC){1'b0}}, level_type};
          `CIE_OFF_CORECTRL: S_AXI_RDATA <= {31'h0, reloc};
          `CIE_OFF_STATUS: S_AXI_RDATA <= {24'h0, status_flags_register};
          `CIE_OFF_SP: S_AXI_RDATA <= {16'h0, sp};
          `CIE_OFF_PC: S_AXI_RDATA <= {{(32-PCW){1'b0}}, PROGRAM_COUNTER};
          `CIE_OFF_CMD: S_AXI_RDATA <= {24'h0, cmd_reg};
          `CIE_OFF_VECTOR: S_AXI_RDATA <= {{(32-PCW){1'b0}}, vec_addr};
          `CIE_OFF_STATE: S_AXI_RDATA <= {23'h0, hold_one, cur, 2'h0,
            state};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `CIE_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

//--- tb/cie_core_asserts.sv
`timescale 1ns/1ps
// Watches entry pushes, vectors and bus answers at the core's pins.
module cie_core_asserts #(
  parameter PCW = 13
) (
  input wire CORE_CLK, // CPU clock.
  input wire RST, // Reset, active high.
  input wire INSTR_DONE, // Instruction boundary.
  input wire [PCW-1:0] PROGRAM_COUNTER, // Program counter.
  input wire STACK_WE, // Push strobe.
  input wire [15:0] STACK_ADDR, // Push address.
  input wire [7:0] STACK_WDATA, // Push byte.
  input wire CORE_STALL, // Sequencer held.
  input wire S_AXI_BVALID, // Write answer.
  input wire S_AXI_BREADY, // Write answer taken.
  input wire S_AXI_RVALID, // Read answer.
  input wire S_AXI_RREADY // Read answer taken.
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  push_pair_a: assert property ($rose(STACK_WE) |=> STACK_WE ##1 !STACK_WE)
    else $error("return address push is not two bytes");
  push_down_a: assert property ($rose(STACK_WE) |=>
    STACK_ADDR == $past(STACK_ADDR) - 16'h0001)
    else $error("second push byte not one address lower");
  push_low_a: assert property ($rose(STACK_WE) |->
    STACK_WDATA == PROGRAM_COUNTER[7:0])
    else $error("first push byte is not the counter low byte");
  push_high_a: assert property ($rose(STACK_WE) |=>
    STACK_WDATA == {3'h0, PROGRAM_COUNTER[PCW-1:8]})
    else $error("second push byte is not the counter high part");
  entry_stall_a: assert property ($rose(STACK_WE) |-> CORE_STALL[*4])
    else $error("sequencer not held through entry");
  take_boundary_a: assert property ($rose(STACK_WE) |->
    $past(INSTR_DONE, 2) || $past(CORE_STALL, 2))
    else $error("entry taken away from an instruction boundary");
  vector_pc_a: assert property ($fell(STACK_WE) |-> ##[1:3]
    (PROGRAM_COUNTER[0] == 1'b0 && PROGRAM_COUNTER != 13'h0000 &&
    (PROGRAM_COUNTER < 13'h0012 || PROGRAM_COUNTER >= 13'h1C00)))
    else $error("counter did not reach a vector slot");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID)
    else $error("write answer dropped before taken");
  rresp_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID)
    else $error("read answer dropped before taken");

  cover property ($rose(STACK_WE));
  cover property ($fell(CORE_STALL));
  cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind cie_core cie_core_asserts #(.PCW(PCW)) u_cie_core_asserts (
  .CORE_CLK(CORE_CLK), .RST(RST), .INSTR_DONE(INSTR_DONE),
  .PROGRAM_COUNTER(PROGRAM_COUNTER), .STACK_WE(STACK_WE),
  .STACK_ADDR(STACK_ADDR), .STACK_WDATA(STACK_WDATA),
  .CORE_STALL(CORE_STALL), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

//--- tb/cie_seq_model.sv
`timescale 1ns/1ps
// Execute sequencer stand-in: instructions of LEN cycles, frozen on stall.
module cie_seq_model #(
  parameter LEN = 2
) (
  input wire clk, // CPU clock.
  input wire rst, // Reset, active high.
  input wire stall, // Core holds the sequencer.
  output reg done // Boundary of an instruction.
);
  reg [3:0] cnt;

  // A boundary only at the last cycle, so longer instructions finish first.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (stall) begin
      done <= 1'b0;
    end else if (cnt == LEN - 1) begin
      cnt <= 4'h0;
      done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
      done <= 1'b0;
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "cie_regs.vh"
// Drives the core over its register bus and watches its stack pins.
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] src_event = 8'h00;
  reg [7:0] src_level = 8'h00;
  reg [31:0] awaddr = 32'h0;
  reg [31:0] wdata = 32'h0;
  reg [31:0] araddr = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg we_d = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, done, stack_we, stall;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] pc;
  wire [15:0] stack_addr;
  wire [7:0] stack_wdata;
  integer takes = 0;
  integer err_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  reg [31:0] d;
  reg [1:0] r;
  reg [1:0] wresp;

  // The clock toggles every half period.
  always #2.5 clk = ~clk;

  cie_core u_cie_core (.CORE_CLK(clk), .RST(rst), .SRC_EVENT(src_event),
    .SRC_LEVEL(src_level), .INSTR_DONE(done), .BOOT_RESET_FUSE(1'b0),
    .APP_SECTION_LOCK_BIT(1'b0), .BOOT_SECTION_LOCK_BIT(1'b0),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PROGRAM_COUNTER(pc), .STACK_WE(stack_we),
    .STACK_ADDR(stack_addr), .STACK_WDATA(stack_wdata),
    .CORE_STALL(stall));

  cie_seq_model u_cie_seq_model (.clk(clk), .rst(rst), .stall(stall),
    .done(done));

  // Entries are counted by their first push; a hang is cut short here.
  always @(posedge clk) begin
    we_d <= stack_we;
    if (stack_we === 1'b1 && we_d === 1'b0) takes = takes + 1;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // Address and data go out together; each drops as soon as it is taken.
  task wr(input [7:0] a, input [31:0] v);
    reg aw;
    reg w;
    begin
      aw = 1'b0;
      w = 1'b0;
      awaddr <= {24'h0, a};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
        @(posedge clk);
        if (awready === 1'b1 && !aw) begin
          aw = 1'b1;
          awvalid <= 1'b0;
        end
        if (wready === 1'b1 && !w) begin
          w = 1'b1;
          wvalid <= 1'b0;
        end
      end
      // Hold off bready a while so the slave must keep its answer up.
      repeat (2) @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      while (bvalid !== 1'b1) @(posedge clk);
      wresp = bresp;
      bready <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    begin
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      @(posedge clk);
      while (arready !== 1'b1) @(posedge clk);
      arvalid <= 1'b0;
      // Ready comes late on purpose; the answer has to wait for it.
      @(posedge clk);
      rready <= 1'b1;
      @(posedge clk);
      while (rvalid !== 1'b1) @(posedge clk);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rchk(input string name, input [7:0] a, input [31:0] exp);
    begin
      rd(a, d, r);
      chk(name, exp, d);
    end
  endtask

  task pulse(input [7:0] m);
    begin
      src_event <= m;
      @(posedge clk);
      src_event <= 8'h00;
      repeat (2) @(posedge clk);
    end
  endtask

  // Waits for one entry beyond n0 and for the vector jump to finish.
  task wait_take(input integer n0);
    integer i;
    begin
      i = 0;
      while (takes == n0 && i < 300) begin
        @(posedge clk);
        i = i + 1;
      end
      chk("entries", n0 + 1, takes);
      while (stall !== 1'b0 && i < 600) begin
        @(posedge clk);
        i = i + 1;
      end
    end
  endtask

  task t_reset;
    begin
      rchk("status", `CIE_OFF_STATUS, 32'h0);
      rchk("sp", `CIE_OFF_SP, 32'h04FF);
      rchk("pc", `CIE_OFF_PC, 32'h0);
      rd(8'h40, d, r);
      chk("rresp", 32'h2, {30'h0, r});
      wr(`CIE_OFF_VECTOR, 32'h0);
      chk("bresp", 32'h2, {30'h0, wresp});
      $display("t_reset done");
    end
  endtask

  task t_flag;
    begin
      wr(`CIE_OFF_ENABLE, 32'h0);
      pulse(8'h08);
      rchk("flag", `CIE_OFF_FLAG, 32'h08);
      wr(`CIE_OFF_FLAG, 32'h0);
      rchk("flag", `CIE_OFF_FLAG, 32'h08);
      wr(`CIE_OFF_FLAG, 32'h08);
      rchk("flag", `CIE_OFF_FLAG, 32'h0);
      $display("t_flag done");
    end
  endtask

  // Two held flags are served lowest index first once enabled globally.
  task t_entry;
    integer n;
    begin
      wr(`CIE_OFF_ENABLE, 32'h24);
      pulse(8'h24);
      repeat (20) @(posedge clk);
      chk("entries", 0, takes);
      n = takes;
      wr(`CIE_OFF_CMD, 32'h2);
      wait_take(n);
      rchk("pc", `CIE_OFF_PC, 32'h6);
      rchk("vector", `CIE_OFF_VECTOR, 32'hC);
      rchk("status", `CIE_OFF_STATUS, 32'h0);
      rchk("flag", `CIE_OFF_FLAG, 32'h20);
      rchk("sp", `CIE_OFF_SP, 32'h04FD);
      n = takes;
      wr(`CIE_OFF_CMD, 32'h4);
      wait_take(n);
      rchk("pc", `CIE_OFF_PC, 32'hC);
      rchk("flag", `CIE_OFF_FLAG, 32'h0);
      wr(`CIE_OFF_CMD, 32'h4);
      repeat (8) @(posedge clk);
      rchk("sp", `CIE_OFF_SP, 32'h04FF);
      rchk("status", `CIE_OFF_STATUS, 32'h80);
      $display("t_entry done");
    end
  endtask

  task t_cli;
    integer n;
    begin
      wr(`CIE_OFF_CMD, 32'h1);
      wr(`CIE_OFF_ENABLE, 32'h10);
      n = takes;
      pulse(8'h10);
      repeat (20) @(posedge clk);
      chk("entries", n, takes);
      wr(`CIE_OFF_CORECTRL, 32'h1);
      wr(`CIE_OFF_CMD, 32'h2);
      wait_take(n);
      rchk("pc", `CIE_OFF_PC, 32'h1C0A);
      wr(`CIE_OFF_CMD, 32'h4);
      wr(`CIE_OFF_CORECTRL, 32'h0);
      $display("t_cli done");
    end
  endtask

  // A level condition that goes away before enabling must not be served.
  task t_level;
    integer n;
    begin
      wr(`CIE_OFF_ENABLE, 32'h0);
      wr(`CIE_OFF_LEVELTYPE, 32'h02);
      n = takes;
      src_level <= 8'h02;
      repeat (4) @(posedge clk);
      src_level <= 8'h00;
      wr(`CIE_OFF_ENABLE, 32'h02);
      repeat (20) @(posedge clk);
      chk("entries", n, takes);
      src_level <= 8'h02;
      wait_take(n);
      src_level <= 8'h00;
      rchk("pc", `CIE_OFF_PC, 32'h4);
      wr(`CIE_OFF_CMD, 32'h4);
      $display("t_level done");
    end
  endtask

  // Asleep, the wake-up clocks come ahead of the usual entry.
  task t_sleep;
    integer n;
    begin
      wr(`CIE_OFF_ENABLE, 32'h01);
      wr(`CIE_OFF_CMD, 32'h10);
      n = takes;
      pulse(8'h01);
      repeat (3) @(posedge clk);
      chk("entries", n, takes);
      wait_take(n);
      rchk("pc", `CIE_OFF_PC, 32'h2);
      rchk("flag", `CIE_OFF_FLAG, 32'h0);
      wr(`CIE_OFF_CMD, 32'h4);
      $display("t_sleep done");
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_flag;
    t_entry;
    t_cli;
    t_level;
    t_sleep;
    end_of_test;
  end
endmodule
